// file: hw/ebpfe_defs.svh
// Offsets, field positions, mode values and counts of the external bus port front end.
`ifndef EBPFE_DEFS_SVH
`define EBPFE_DEFS_SVH
`define EBPFE_OFF_MODE_CFG   8'h00
`define EBPFE_OFF_ADDR_MAP   8'h04
`define EBPFE_OFF_PROTECT    8'h08
`define EBPFE_OFF_RT_WINDOW  8'h0c
`define EBPFE_OFF_RD_ADDR0   8'h10
`define EBPFE_OFF_RD_SIZE0   8'h14
`define EBPFE_OFF_RD_DATA0   8'h18
`define EBPFE_OFF_RD_ADDR1   8'h1c
`define EBPFE_OFF_RD_SIZE1   8'h20
`define EBPFE_OFF_RD_DATA1   8'h24
`define EBPFE_OFF_INT_MASK   8'h28
`define EBPFE_OFF_INT_RAW    8'h2c
`define EBPFE_OFF_INT_MSTAT  8'h30
`define EBPFE_OFF_INT_CLEAR  8'h34
`define EBPFE_OFF_NBR_POP    8'h38
`define EBPFE_OFF_STATUS     8'h3c
`define EBPFE_MODE_GP        2'h0
`define EBPFE_MODE_SDRAM     2'h1
`define EBPFE_DIV4_BIT       2
`define EBPFE_RT_EN_BIT      16
`define EBPFE_CS_MSB         29
`define EBPFE_REMAP_BIT      31
`define EBPFE_INT_NBR        0
`define EBPFE_INT_DONE       1
`define EBPFE_INT_PROT       2
`define EBPFE_INT_WQ_EMPTY   3
`define EBPFE_WQ_DEPTH       4
`define EBPFE_NBR_DEPTH      8
`define EBPFE_WORD_STEP      32'h0000_0004
`define EBPFE_MASTER_VECTOR  69
`define EBPFE_DMA_CH_A       20
`define EBPFE_DMA_CH_B       22
`endif

// file: hw/ebpfe_pkg.sv
// Types shared by the external bus port front end.
package ebpfe_pkg;
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [31:0] addr;
      logic [31:0] wdata;
   } ebpfe_req_t;

   typedef struct packed {
      logic        ready;
      logic        err;
      logic [31:0] rdata;
   } ebpfe_rsp_t;

   typedef struct packed {
      logic gp;
      logic sdram;
      logic host;
   } ebpfe_sel_t;

   typedef enum logic [1:0] {EB_IDLE, EB_WRITE, EB_BLOCK, EB_BACK} ebpfe_state_t;
endpackage : ebpfe_pkg

// file: hw/ebpfe_top.sv
// External bus port front end: arbitration, protection, queues, reads and interrupts.
// Notes on behaviour
// - Each accepted cycle goes to exactly one mode sub-block chosen by mode field.
// - Writes enter a four-deep queue; a granted requester stalls only when it is full.
// - With read-data registers zero, reads block the requester until completion.
// - Nonzero write to read-data launches background reads from address and size.
// - Background read data enters the read queue and raises the port interrupt.
// - Two read register sets; one drains while the other fills.
// - Interrupt drives master vector, two master DMA channels, control expander line.
// - Four interrupt registers: mask, raw, masked status and clear.
// - Address passes unchanged or is remapped by map register and top bit.
// - Master wins over control unless a real-time window gives control ownership.
// - Protection bits give chip-select spaces to master, control or both.
// - Control side may write only real-time window; master writes all else.
// - Control requests are taken only on a divide-by-two or four enable.
// - In revision zero the control side never reaches the port.
// - Mode value zero selects the general-purpose sub-block.
//
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/1ns
`include "ebpfe_defs.svh"
module ebpfe_top
   import ebpfe_pkg::*;
#(
   parameter int WQ_DEPTH    = `EBPFE_WQ_DEPTH,
   parameter int NBR_DEPTH   = `EBPFE_NBR_DEPTH,
   parameter int SILICON_REV = 1
) (
   // Clock and reset.
   input  wire logic        CLK,
   input  wire logic        RST_B,
   // APB register slave.
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   input  wire logic        PCTRL_SIDE,
   output logic [31:0]      PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   // Master side and control side requesters.
   input  ebpfe_req_t       M_REQ,
   output ebpfe_rsp_t       M_RSP,
   input  ebpfe_req_t       C_REQ,
   output ebpfe_rsp_t       C_RSP,
   // Operation towards the mode sub-blocks.
   output ebpfe_req_t       EXT_OP,
   output ebpfe_sel_t       EXT_SEL,
   input  wire logic        EXT_DONE,
   input  wire logic [31:0] EXT_RDATA,
   // Interrupt outputs.
   output logic             INT_MASTER_CPU,
   output logic             DMA_REQ_A,
   output logic             DMA_REQ_B,
   output logic             INT_CONTROL_LINE
);
   localparam int WA = $clog2(WQ_DEPTH);
   localparam int NA = $clog2(NBR_DEPTH);

   typedef struct packed {
      logic [1:0]                  mode;
      logic                        div4;
      logic                        map_en;
      logic [3:0]                  map_base;
      logic [7:0]                  prot;
      logic                        rt_en;
      logic [15:0]                 rt_len;
      logic [15:0]                 rt_cnt;
      logic [1:0]                  div_cnt;
      logic [1:0][31:0]            rd_addr;
      logic [1:0][31:0]            rd_size;
      logic [1:0][31:0]            rd_data;
      logic [3:0]                  int_mask;
      logic [3:0]                  int_raw;
      logic [WQ_DEPTH-1:0][63:0]   wq;
      logic [WA-1:0]               wq_rd;
      logic [WA-1:0]               wq_wr;
      logic [WA:0]                 wq_n;
      logic [NBR_DEPTH-1:0][31:0]  nq;
      logic [NA-1:0]               nq_rd;
      logic [NA-1:0]               nq_wr;
      logic [NA:0]                 nq_n;
      ebpfe_state_t                state;
      ebpfe_req_t                  op;
      ebpfe_sel_t                  sel;
      logic                        pend;
      logic                        pend_c;
      logic [31:0]                 pend_addr;
      logic [1:0]                  ack;
      logic [31:0]                 rdata;
      logic                        nb_run;
      logic                        nb_set;
      logic                        nb_next;
      logic [31:0]                 nb_cnt;
      logic [31:0]                 nb_addr;
      logic                        apb_rdy;
      logic                        apb_err;
      logic [31:0]                 prdata;
   } ebpfe_st_t;

   ebpfe_st_t  st;
   ebpfe_st_t  next_st;
   logic [1:0] rst_q;
   logic       rst_n;

   // Maps the top address bit region onto the programmed base.
   function automatic logic [31:0] f_remap(input logic [31:0] a, input logic en,
                                           input logic [3:0] base);
      f_remap = (en && a[`EBPFE_REMAP_BIT]) ? {base, a[27:0]} : a;
   endfunction : f_remap

   // Tells whether a side owns the chip-select space of an address.
   function automatic logic f_allowed(input logic [7:0] prot, input logic [31:0] a,
                                      input logic side);
      logic [1:0] cs;
      cs = a[`EBPFE_CS_MSB -: 2];
      f_allowed = prot[{cs, side}];
   endfunction : f_allowed

   // Decodes the mode field into one sub-block select.
   function automatic ebpfe_sel_t f_sel(input logic [1:0] mode);
      f_sel.gp    = (mode == `EBPFE_MODE_GP);
      f_sel.sdram = (mode == `EBPFE_MODE_SDRAM);
      f_sel.host  = !f_sel.gp && !f_sel.sdram;
   endfunction : f_sel

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         rst_q <= 2'h0;
      end else begin
         rst_q <= {rst_q[0], 1'b1};
      end
   end
   assign rst_n = rst_q[1];

   logic       ctrl_en;
   logic       window;
   logic       c_ok;
   logic       gnt_m;
   logic       gnt_c;
   logic       ok;
   logic       take;
   logic       push_w;
   logic       pop_w;
   logic       push_n;
   logic       pop_n;
   logic       s;
   logic       access;
   logic [3:0] evt;
   ebpfe_req_t req;

   always_comb begin
      next_st = st;
      next_st.ack = 2'h0;
      evt = 4'h0;
      push_w = 1'b0;
      pop_w = 1'b0;
      push_n = 1'b0;
      pop_n = 1'b0;
      ctrl_en = (st.div_cnt == (st.div4 ? 2'h3 : 2'h1));
      next_st.div_cnt = ctrl_en ? 2'h0 : st.div_cnt + 2'h1;
      window = (st.rt_cnt != 16'h0);
      if (window) begin
         next_st.rt_cnt = st.rt_cnt - 16'h1;
      end
      c_ok = (SILICON_REV != 0) && C_REQ.valid && ctrl_en;
      if (c_ok && st.rt_en && !window) begin
         next_st.rt_cnt = st.rt_len;
      end
      gnt_m = M_REQ.valid && !window;
      gnt_c = c_ok && !gnt_m;
      req = gnt_c ? C_REQ : M_REQ;
      ok = f_allowed(st.prot, req.addr, gnt_c);
      take = 1'b0;
      if (gnt_m || gnt_c) begin
         if (!ok) begin
            take = 1'b1;
            evt[`EBPFE_INT_PROT] = 1'b1;
         end else if (req.write && st.wq_n != (WA+1)'(WQ_DEPTH)) begin
            take = 1'b1;
            push_w = 1'b1;
            next_st.wq[st.wq_wr] = {req.addr, req.wdata};
         end else if (!req.write && !st.pend && st.ack == 2'h0
                      && st.rd_data[0] == 32'h0 && st.rd_data[1] == 32'h0) begin
            next_st.pend = 1'b1;
            next_st.pend_c = gnt_c;
            next_st.pend_addr = req.addr;
         end
      end
      if (!st.nb_run) begin
         s = (st.rd_data[st.nb_next] != 32'h0) ? st.nb_next : !st.nb_next;
         if (st.rd_data[s] != 32'h0) begin
            if (st.rd_size[s] == 32'h0) begin
               next_st.rd_data[s] = 32'h0;
               evt[`EBPFE_INT_DONE] = 1'b1;
            end else begin
               next_st.nb_run = 1'b1;
               next_st.nb_set = s;
               next_st.nb_cnt = st.rd_size[s];
               next_st.nb_addr = st.rd_addr[s];
            end
         end
      end else begin
         s = st.nb_set;
      end
      case (st.state)
         EB_IDLE: begin
            next_st.sel = f_sel(st.mode);
            if (st.wq_n != '0) begin
               pop_w = 1'b1;
               next_st.op = {1'b1, 1'b1, f_remap(st.wq[st.wq_rd][63:32], st.map_en,
                             st.map_base), st.wq[st.wq_rd][31:0]};
               next_st.state = EB_WRITE;
            end else if (st.pend) begin
               next_st.op = {1'b1, 1'b0, f_remap(st.pend_addr, st.map_en, st.map_base),
                             32'h0};
               next_st.state = EB_BLOCK;
            end else if (st.nb_run && st.nq_n != (NA+1)'(NBR_DEPTH)) begin
               next_st.op = {1'b1, 1'b0, f_remap(st.nb_addr, st.map_en, st.map_base),
                             32'h0};
               next_st.state = EB_BACK;
            end
         end
         EB_WRITE: begin
            if (EXT_DONE) begin
               next_st.op.valid = 1'b0;
               next_st.state = EB_IDLE;
               evt[`EBPFE_INT_WQ_EMPTY] = (st.wq_n == '0) && !push_w;
            end
         end
         EB_BLOCK: begin
            if (EXT_DONE) begin
               next_st.op.valid = 1'b0;
               next_st.state = EB_IDLE;
               next_st.rdata = EXT_RDATA;
               next_st.ack[st.pend_c] = 1'b1;
               next_st.pend = 1'b0;
            end
         end
         EB_BACK: begin
            if (EXT_DONE) begin
               next_st.op.valid = 1'b0;
               next_st.state = EB_IDLE;
               push_n = 1'b1;
               next_st.nq[st.nq_wr] = EXT_RDATA;
               evt[`EBPFE_INT_NBR] = 1'b1;
               next_st.nb_addr = st.nb_addr + `EBPFE_WORD_STEP;
               next_st.nb_cnt = st.nb_cnt - 32'h1;
               if (st.nb_cnt == 32'h1) begin
                  next_st.nb_run = 1'b0;
                  next_st.rd_data[st.nb_set] = 32'h0;
                  next_st.nb_next = !st.nb_set;
                  evt[`EBPFE_INT_DONE] = 1'b1;
               end
            end
         end
         default: begin
            next_st.state = EB_IDLE;
            next_st.op.valid = 1'b0;
         end
      endcase
      next_st.apb_rdy = PSEL && !PENABLE;
      access = PSEL && PENABLE && st.apb_rdy;
      if (PSEL && !PENABLE) begin
         next_st.apb_err = 1'b0;
         if (PWRITE && PCTRL_SIDE && PADDR != `EBPFE_OFF_RT_WINDOW) begin
            next_st.apb_err = 1'b1;
         end
         case (PADDR)
            `EBPFE_OFF_MODE_CFG:  next_st.prdata = {29'h0, st.div4, st.mode};
            `EBPFE_OFF_ADDR_MAP:  next_st.prdata = {24'h0, st.map_base, 3'h0, st.map_en};
            `EBPFE_OFF_PROTECT:   next_st.prdata = {24'h0, st.prot};
            `EBPFE_OFF_RT_WINDOW: next_st.prdata = {15'h0, st.rt_en, st.rt_len};
            `EBPFE_OFF_RD_ADDR0:  next_st.prdata = st.rd_addr[0];
            `EBPFE_OFF_RD_SIZE0:  next_st.prdata = st.rd_size[0];
            `EBPFE_OFF_RD_DATA0:  next_st.prdata = st.rd_data[0];
            `EBPFE_OFF_RD_ADDR1:  next_st.prdata = st.rd_addr[1];
            `EBPFE_OFF_RD_SIZE1:  next_st.prdata = st.rd_size[1];
            `EBPFE_OFF_RD_DATA1:  next_st.prdata = st.rd_data[1];
            `EBPFE_OFF_INT_MASK:  next_st.prdata = {28'h0, st.int_mask};
            `EBPFE_OFF_INT_RAW:   next_st.prdata = {28'h0, st.int_raw};
            `EBPFE_OFF_INT_MSTAT: next_st.prdata = {28'h0, st.int_raw & st.int_mask};
            `EBPFE_OFF_INT_CLEAR: next_st.prdata = 32'h0;
            `EBPFE_OFF_NBR_POP:   next_st.prdata = (st.nq_n != '0) ? st.nq[st.nq_rd] : 32'h0;
            `EBPFE_OFF_STATUS:    next_st.prdata = {16'h0, st.state, st.nb_run, st.pend,
                                                    4'(st.nq_n), 4'(st.wq_n), 4'h0};
            default: begin
               next_st.prdata = 32'h0;
               next_st.apb_err = 1'b1;
            end
         endcase
      end
      if (access && PWRITE && !st.apb_err) begin
         case (PADDR)
            `EBPFE_OFF_MODE_CFG: begin
               next_st.mode = PWDATA[1:0];
               next_st.div4 = PWDATA[`EBPFE_DIV4_BIT];
            end
            `EBPFE_OFF_ADDR_MAP: begin
               next_st.map_en = PWDATA[0];
               next_st.map_base = PWDATA[7:4];
            end
            `EBPFE_OFF_PROTECT:   next_st.prot = PWDATA[7:0];
            `EBPFE_OFF_RT_WINDOW: begin
               next_st.rt_len = PWDATA[15:0];
               next_st.rt_en = PWDATA[`EBPFE_RT_EN_BIT];
            end
            `EBPFE_OFF_RD_ADDR0:  next_st.rd_addr[0] = PWDATA;
            `EBPFE_OFF_RD_SIZE0:  next_st.rd_size[0] = PWDATA;
            `EBPFE_OFF_RD_DATA0:  next_st.rd_data[0] = PWDATA;
            `EBPFE_OFF_RD_ADDR1:  next_st.rd_addr[1] = PWDATA;
            `EBPFE_OFF_RD_SIZE1:  next_st.rd_size[1] = PWDATA;
            `EBPFE_OFF_RD_DATA1:  next_st.rd_data[1] = PWDATA;
            `EBPFE_OFF_INT_MASK:  next_st.int_mask = PWDATA[3:0];
            `EBPFE_OFF_INT_CLEAR: next_st.int_raw = st.int_raw & ~PWDATA[3:0];
            default: begin
            end
         endcase
      end
      if (access && !PWRITE && PADDR == `EBPFE_OFF_NBR_POP && st.nq_n != '0) begin
         pop_n = 1'b1;
      end
      next_st.int_raw = next_st.int_raw | evt;
      next_st.wq_wr = st.wq_wr + WA'(push_w);
      next_st.wq_rd = st.wq_rd + WA'(pop_w);
      next_st.wq_n = st.wq_n + (WA+1)'(push_w) - (WA+1)'(pop_w);
      next_st.nq_wr = st.nq_wr + NA'(push_n);
      next_st.nq_rd = st.nq_rd + NA'(pop_n);
      next_st.nq_n = st.nq_n + (NA+1)'(push_n) - (NA+1)'(pop_n);
      M_RSP.ready = (gnt_m && take) || st.ack[0];
      M_RSP.err = gnt_m && take && !ok;
      M_RSP.rdata = st.rdata;
      C_RSP.ready = (gnt_c && take) || st.ack[1];
      C_RSP.err = gnt_c && take && !ok;
      C_RSP.rdata = st.rdata;
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign PRDATA = st.prdata;
   assign PREADY = st.apb_rdy;
   assign PSLVERR = st.apb_rdy && st.apb_err;
   assign EXT_OP = st.op;
   assign EXT_SEL = st.op.valid ? st.sel : '0;
   // One level feeds the master vector, both DMA channels and the control expander.
   assign INT_MASTER_CPU = |(st.int_raw & st.int_mask);
   assign DMA_REQ_A = INT_MASTER_CPU;
   assign DMA_REQ_B = INT_MASTER_CPU;
   assign INT_CONTROL_LINE = INT_MASTER_CPU;
endmodule : ebpfe_top

// file: verif/ebpfe_sva.sv
// Checker of the external bus port front end, watching the top ports only.
`timescale 1ns/1ns
`include "ebpfe_defs.svh"
module ebpfe_sva
   import ebpfe_pkg::*;
#(
   parameter int WQ_DEPTH = 4
) (
   // Clock, reset and register bus.
   input wire logic        CLK,
   input wire logic        RST_B,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [7:0]  PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic        PCTRL_SIDE,
   input wire logic        PREADY,
   input wire logic        PSLVERR,
   // Requesters and the operation towards the sub-blocks.
   input ebpfe_req_t       M_REQ,
   input ebpfe_rsp_t       M_RSP,
   input ebpfe_req_t       C_REQ,
   input ebpfe_rsp_t       C_RSP,
   input ebpfe_req_t       EXT_OP,
   input ebpfe_sel_t       EXT_SEL,
   input wire logic        EXT_DONE,
   input wire logic [31:0] EXT_RDATA,
   // Interrupt outputs.
   input wire logic        INT_MASTER_CPU,
   input wire logic        DMA_REQ_A,
   input wire logic        DMA_REQ_B,
   input wire logic        INT_CONTROL_LINE
);
   logic [1:0] mode;
   logic [7:0] prot;
   logic       v_q, wr_ok, iss_w, acc_m, acc_c;
   int         wq;
   // Shadow copies of mode and protection, and a count of writes not yet issued.
   assign wr_ok = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;
   assign iss_w = EXT_OP.valid && !v_q && EXT_OP.write;
   assign acc_m = M_REQ.valid && M_REQ.write && M_RSP.ready && !M_RSP.err;
   assign acc_c = C_REQ.valid && C_REQ.write && C_RSP.ready && !C_RSP.err;
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         mode <= 2'h0;
         prot <= 8'h00;
         v_q  <= 1'b0;
         wq   <= 0;
      end else begin
         if (wr_ok && PADDR == `EBPFE_OFF_MODE_CFG) mode <= PWDATA[1:0];
         if (wr_ok && PADDR == `EBPFE_OFF_PROTECT) prot <= PWDATA[7:0];
         v_q <= EXT_OP.valid;
         wq  <= wq + int'(acc_m) + int'(acc_c) - int'(iss_w);
      end
   end
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B);
   chk_sel_onehot: assert property ($onehot(EXT_SEL) == EXT_OP.valid)
      else $error("select not one-hot with the operation");
   chk_mode_route: assert property (EXT_OP.valid |-> EXT_SEL.sdram == (mode == 2'h1))
      else $error("sdram select does not follow the mode");
   chk_gp_mode: assert property (EXT_OP.valid && mode == 2'h0 |-> EXT_SEL.gp)
      else $error("mode zero did not select general purpose");
   chk_op_hold: assert property (EXT_OP.valid && !EXT_DONE |=> EXT_OP.valid && $stable(EXT_OP))
      else $error("operation changed before completion");
   chk_int_same: assert property (INT_MASTER_CPU == DMA_REQ_A && DMA_REQ_A == DMA_REQ_B
      && DMA_REQ_B == INT_CONTROL_LINE)
      else $error("interrupt outputs differ");
   chk_ctrl_refuse: assert property (PSEL && !PENABLE && PWRITE && PCTRL_SIDE
      && PADDR != `EBPFE_OFF_RT_WINDOW |=> PREADY && PSLVERR)
      else $error("control side write not refused");
   chk_wq_limit: assert property (acc_m |-> wq - int'(iss_w) < WQ_DEPTH)
      else $error("write accepted into a full queue");
   chk_rd_drain: assert property (EXT_OP.valid && !v_q && !EXT_OP.write |-> wq == 0)
      else $error("read issued ahead of queued writes");
   chk_rd_data: assert property (M_RSP.ready && !M_RSP.err && M_REQ.valid && !M_REQ.write
      |-> $past(EXT_DONE) && M_RSP.rdata == $past(EXT_RDATA))
      else $error("blocking read answered without completed bus read");
   chk_prot_m: assert property (M_REQ.valid && M_RSP.ready
      |-> M_RSP.err == !prot[{M_REQ.addr[29:28], 1'b0}])
      else $error("master ownership not applied");
   chk_prot_c: assert property (C_REQ.valid && C_RSP.ready
      |-> C_RSP.err == !prot[{C_REQ.addr[29:28], 1'b1}])
      else $error("control ownership not applied");
   cov_read: cover property (EXT_OP.valid && !v_q && !EXT_OP.write);
   cov_refuse: cover property (M_RSP.ready && M_RSP.err);
   cov_ctrl: cover property (C_RSP.ready && !C_RSP.err);
   cov_int: cover property (INT_MASTER_CPU);
endmodule : ebpfe_sva

// file: verif/ebpfe_ext_model.sv
// Model of the external device answering operations after a chosen latency.
`timescale 1ns/1ns
module ebpfe_ext_model
   import ebpfe_pkg::*;
#(
   parameter logic [31:0] RD_KEY = 32'h5a5a_0000
) (
   // Clock and reset.
   input wire logic        clk,
   input wire logic        rst_b,
   // Operation and answer.
   input ebpfe_req_t       op,
   input wire logic [7:0]  lat,
   output logic            done,
   output logic [31:0]     rdata
);
   ebpfe_req_t wlog[$];
   logic [7:0] cnt;
   // Read data is valid only with done; otherwise it toggles every cycle.
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         done  <= 1'b0;
         cnt   <= 8'h00;
         rdata <= 32'h0000_0000;
      end else if (op.valid && !done && cnt >= lat) begin
         done  <= 1'b1;
         rdata <= op.addr ^ RD_KEY;
         if (op.write) wlog.push_back(op);
      end else begin
         done  <= 1'b0;
         cnt   <= (op.valid && !done) ? cnt + 8'h01 : 8'h00;
         rdata <= ~rdata;
      end
   end
endmodule : ebpfe_ext_model

// file: verif/tb_top.sv
// Testbench of the external bus port front end.
`timescale 1ns/1ns
`include "ebpfe_defs.svh"
module tb_top;
   import ebpfe_pkg::*;
   localparam logic [31:0] KEY = 32'h5a5a_0000;
   logic        CLK, RST_B, PSEL, PENABLE, PWRITE, PCTRL_SIDE, EXT_DONE, e, re;
   logic        PREADY, PSLVERR, INT_MASTER_CPU, DMA_REQ_A, DMA_REQ_B, INT_CONTROL_LINE;
   logic [7:0]  PADDR, lat;
   logic [31:0] PWDATA, PRDATA, EXT_RDATA, q, rq;
   ebpfe_req_t  M_REQ, C_REQ, EXT_OP;
   ebpfe_rsp_t  M_RSP, C_RSP;
   ebpfe_sel_t  EXT_SEL, last_sel;
   int          err_count, num_checks, wt, n, w[6];
   ebpfe_top ebpfe_top_inst (.CLK, .RST_B, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
      .PCTRL_SIDE, .PRDATA, .PREADY, .PSLVERR, .M_REQ, .M_RSP, .C_REQ, .C_RSP, .EXT_OP,
      .EXT_SEL, .EXT_DONE, .EXT_RDATA, .INT_MASTER_CPU, .DMA_REQ_A, .DMA_REQ_B,
      .INT_CONTROL_LINE);
   ebpfe_ext_model #(.RD_KEY(KEY)) ebpfe_ext_model_inst (.clk(CLK), .rst_b(RST_B),
      .op(EXT_OP), .lat(lat), .done(EXT_DONE), .rdata(EXT_RDATA));
   always #2 CLK = ~CLK;
   always @(posedge CLK) if (EXT_OP.valid === 1'b1) last_sel <= EXT_SEL;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic apb(input logic w_, s_, input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK);
      PSEL       <= 1'b1;
      PENABLE    <= 1'b0;
      PWRITE     <= w_;
      PADDR      <= a;
      PWDATA     <= d;
      PCTRL_SIDE <= s_;
      @(posedge CLK);
      PENABLE <= 1'b1;
      n = 0;
      do begin
         @(posedge CLK);
         n++;
      end while (PREADY !== 1'b1 && n < 50);
      if (PREADY !== 1'b1) err_count++;
      q = PRDATA;
      e = PSLVERR;
      PSEL    <= 1'b0;
      PENABLE <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, 1'b0, a, d);
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, 1'b0, a, 32'h0000_0000);
      check(q, exp);
   endtask : rdc
   task automatic req(input logic c, w_, input logic [31:0] a, d);
      ebpfe_rsp_t s;
      @(posedge CLK);
      if (c) C_REQ <= '{1'b1, w_, a, d};
      else M_REQ <= '{1'b1, w_, a, d};
      wt = 0;
      do begin
         @(posedge CLK);
         s = c ? C_RSP : M_RSP;
         wt++;
      end while (s.ready !== 1'b1 && wt < 1000);
      if (s.ready !== 1'b1) err_count++;
      rq = s.rdata;
      re = s.err;
      if (c) C_REQ.valid <= 1'b0;
      else M_REQ.valid <= 1'b0;
   endtask : req
   task automatic wdone();
      n = 0;
      do begin
         @(negedge CLK);
         n++;
      end while (EXT_DONE !== 1'b1 && n < 500);
      if (EXT_DONE !== 1'b1) err_count++;
   endtask : wdone
   task automatic ichk(input logic exp);
      repeat (2) @(negedge CLK);
      check({28'h0, INT_MASTER_CPU, DMA_REQ_A, DMA_REQ_B, INT_CONTROL_LINE}, {28'h0, {4{exp}}});
   endtask : ichk
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : report_and_stop
   initial begin
      #40000;
      err_count++;
      report_and_stop();
   end
   initial begin
      {CLK, RST_B, PSEL, PENABLE, PWRITE, PCTRL_SIDE} = 6'h00;
      {PADDR, PWDATA, lat, M_REQ, C_REQ} = '0;
      err_count = 0;
      num_checks = 0;
      repeat (12) @(posedge CLK);
      RST_B <= 1'b1;
      repeat (3) @(posedge CLK);
      rdc(`EBPFE_OFF_MODE_CFG, 32'h0000_0000);
      apb(1'b0, 1'b0, 8'h40, 32'h0000_0000);
      check({31'h0, e}, 32'h1);
      apb(1'b1, 1'b1, `EBPFE_OFF_PROTECT, 32'h0000_00ff);
      check({31'h0, e}, 32'h1);
      rdc(`EBPFE_OFF_PROTECT, 32'h0000_0000);
      apb(1'b1, 1'b1, `EBPFE_OFF_RT_WINDOW, 32'h0000_0005);
      check({31'h0, e}, 32'h0);
      rdc(`EBPFE_OFF_RT_WINDOW, 32'h0000_0005);
      req(1'b0, 1'b1, 32'h0000_0040, 32'h0000_0001);
      check({31'h0, re}, 32'h1);
      rdc(`EBPFE_OFF_INT_RAW, 32'h0000_0004);
      ichk(1'b0);
      wr(`EBPFE_OFF_INT_MASK, 32'h0000_0004);
      ichk(1'b1);
      wr(`EBPFE_OFF_INT_CLEAR, 32'h0000_0004);
      ichk(1'b0);
      wr(`EBPFE_OFF_PROTECT, 32'h0000_000d);
      req(1'b1, 1'b1, 32'h0000_0040, 32'h0000_0001);
      check({31'h0, re}, 32'h1);
      for (int m = 0; m < 4; m++) begin
         wr(`EBPFE_OFF_MODE_CFG, 32'(m));
         req(1'b0, 1'b1, 32'h0000_0100, 32'(m));
         wdone();
         check(32'(last_sel), m == 0 ? 32'h4 : m == 1 ? 32'h2 : 32'h1);
      end
      wr(`EBPFE_OFF_MODE_CFG, 32'h0000_0000);
      lat <= 8'h28;
      for (int i = 0; i < 6; i++) begin
         req(1'b0, 1'b1, 32'h0000_0200 + 32'(4 * i), 32'(i));
         w[i] = wt;
      end
      for (int i = 0; i < 4; i++) check(32'(w[i]), 32'h1);
      check({31'h0, w[5] > 1}, 32'h1);
      req(1'b0, 1'b0, 32'h0000_0300, 32'h0000_0000);
      check(rq, 32'h0000_0300 ^ KEY);
      check(32'(ebpfe_ext_model_inst.wlog.size()), 32'ha);
      for (int i = 0; i < 6; i++)
         check(ebpfe_ext_model_inst.wlog[4 + i].addr, 32'h0000_0200 + 32'(4 * i));
      lat <= 8'h00;
      wr(`EBPFE_OFF_ADDR_MAP, 32'h0000_0031);
      req(1'b0, 1'b1, 32'h8000_0010, 32'h0000_0000);
      wdone();
      check(ebpfe_ext_model_inst.wlog[$].addr, 32'h3000_0010);
      req(1'b0, 1'b1, 32'h0000_0020, 32'h0000_0000);
      wdone();
      check(ebpfe_ext_model_inst.wlog[$].addr, 32'h0000_0020);
      wr(`EBPFE_OFF_ADDR_MAP, 32'h0000_0000);
      wr(`EBPFE_OFF_INT_CLEAR, 32'h0000_000f);
      wr(`EBPFE_OFF_INT_MASK, 32'h0000_0002);
      wr(`EBPFE_OFF_RD_SIZE0, 32'h0000_0002);
      wr(`EBPFE_OFF_RD_ADDR0, 32'h0000_0400);
      wr(`EBPFE_OFF_RD_SIZE1, 32'h0000_0001);
      wr(`EBPFE_OFF_RD_ADDR1, 32'h0000_0500);
      wr(`EBPFE_OFF_RD_DATA0, 32'h0000_0001);
      wr(`EBPFE_OFF_RD_DATA1, 32'h0000_0001);
      wt = 0;
      do begin
         apb(1'b0, 1'b0, `EBPFE_OFF_RD_DATA1, 32'h0000_0000);
         wt++;
      end while (q !== 32'h0000_0000 && wt < 100);
      check(q, 32'h0000_0000);
      rdc(`EBPFE_OFF_RD_DATA0, 32'h0000_0000);
      ichk(1'b1);
      apb(1'b0, 1'b0, `EBPFE_OFF_INT_RAW, 32'h0000_0000);
      check(q & 32'h0000_0003, 32'h0000_0003);
      rdc(`EBPFE_OFF_INT_MSTAT, 32'h0000_0002);
      rdc(`EBPFE_OFF_NBR_POP, 32'h0000_0400 ^ KEY);
      rdc(`EBPFE_OFF_NBR_POP, 32'h0000_0404 ^ KEY);
      rdc(`EBPFE_OFF_NBR_POP, 32'h0000_0500 ^ KEY);
      wr(`EBPFE_OFF_INT_CLEAR, 32'h0000_000f);
      ichk(1'b0);
      req(1'b1, 1'b1, 32'h1000_0040, 32'h0000_0077);
      check({31'h0, re}, 32'h0);
      wdone();
      check(ebpfe_ext_model_inst.wlog[$].wdata, 32'h0000_0077);
      req(1'b1, 1'b0, 32'h1000_0080, 32'h0000_0000);
      check(rq, 32'h1000_0080 ^ KEY);
      apb(1'b1, 1'b1, `EBPFE_OFF_RT_WINDOW, 32'h0001_0008);
      req(1'b1, 1'b1, 32'h1000_0040, 32'h0000_0001);
      req(1'b0, 1'b1, 32'h0000_0040, 32'h0000_0002);
      check({31'h0, wt > 1}, 32'h1);
      report_and_stop();
   end
endmodule : tb_top
bind ebpfe_top ebpfe_sva #(.WQ_DEPTH(WQ_DEPTH)) ebpfe_sva_inst (.CLK, .RST_B, .PSEL,
   .PENABLE, .PWRITE, .PADDR, .PWDATA, .PCTRL_SIDE, .PREADY, .PSLVERR, .M_REQ, .M_RSP,
   .C_REQ, .C_RSP, .EXT_OP, .EXT_SEL, .EXT_DONE, .EXT_RDATA, .INT_MASTER_CPU, .DMA_REQ_A,
   .DMA_REQ_B, .INT_CONTROL_LINE);
